//--- boundary_scan_tap_controller.sv
// Boundary-scan test port: controller, instruction, bypass, identification
// and boundary-scan registers. Assumes cell_in comes from core logic on clk;
// the pin mux outside uses bsr_out, drive_bsr and outputs_hiz.
//
// What this block does
// - Low test reset forces controller reset and register defaults.
// - Sample TMS/TDI and advance on test-clock rise; TDO changes on fall.
// - TMS held high reaches reset state within five test clocks.
// - Reset state disables test logic and loads identification instruction.
// - Reset state clears all boundary cells; no undefined bits are set to one.
// - Select states do nothing and leave on the next test clock.
// - Capture-DR loads selected register on the rise that exits it.
// - Shift states move one stage per rise, from TDI toward TDO.
// - TDO goes high impedance on first fall after entering Exit1.
// - Exit2 states may resume shifting; pause states hold contents.
// - Update-DR loads parallel output on the following test-clock fall, under external test and sample/preload only.
// - Capture-IR loads the fixed pattern on the exiting rise.
// - Update-IR makes the new instruction active on the following fall.
// - Eight-bit instruction decodes mode, operation, register, source.
// - External test: boundary register, capture inputs, drive outputs.
// - Sample/preload: boundary register, capture all, preload, normal mode.
// - High impedance: outputs tri-stated, bypass register captures zero.
// - Clamp: outputs held from boundary register, bypass selected.
// - Bypass and unassigned codes select one-bit bypass capturing zero.
// - Identification instruction connects identification register, normal.
// - Cell test code selects boundary register, normal mode.
// - Cell test captures the inverse of each cell's held value.
// - Identification register is 32 bits and captures the fixed code.
// - Boundary register shifts from TDI through top bit to bit zero.
`include "tap_params.svh"
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_tap_controller
    import tap_pkg::*;
(
    // System
    input  wire logic               clk,
    input  wire logic               rst,
    // Test port pins
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    input  wire logic               trst_n,
    output logic                    tdo,
    output logic                    tdo_oe_n,
    // Boundary cells towards the core and the pin mux
    input  wire logic [`BSR_W-1:0]  cell_in,
    output logic      [`BSR_W-1:0]  bsr_out,
    output logic                    test_mode,
    output logic                    drive_bsr,
    output logic                    outputs_hiz,
    // Controller state, for observation
    output tap_state_t              tap_state
);

    // ------------------------------------------------------------------
    // Pin sampling and test-clock edges
    // ------------------------------------------------------------------
    logic [`SYNC_W-1:0] pins_s;
    logic               trst_n_s;
    logic               tck_s;
    logic               tms_s;
    logic               tdi_s;
    logic               tck_d_r;
    logic               tck_rise;
    logic               tck_fall;
    logic               tap_rst;
    tap_state_t         state;

    pin_sync #(
        .WIDTH (`SYNC_W)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({trst_n, tck, tms, tdi}),
        .dout (pins_s)
    );

    assign {trst_n_s, tck_s, tms_s, tdi_s} = pins_s;

    always_ff @(posedge clk) begin
        if (rst) begin
            tck_d_r <= 1'b0;
        end else begin
            tck_d_r <= tck_s;
        end
    end

    // TMS and TDI pass the same two stages as TCK, so they are sampled
    // with the value they had at the rising edge
    assign tck_rise = tck_s & ~tck_d_r;
    assign tck_fall = ~tck_s & tck_d_r;

    // Test reset needs no test-clock edge, only the two sampling stages
    assign tap_rst = rst | ~trst_n_s;

    tap_fsm u_fsm (
        .clk     (clk),
        .rst     (tap_rst),
        .step    (tck_rise),
        .tms     (tms_s),
        .state_r (state)
    );

    // ------------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------------
    logic [`IR_W-1:0] ir_shift_r;
    logic [`IR_W-1:0] ir_r;
    instr_decode_t    dec;

    always_ff @(posedge clk) begin
        if (tap_rst) begin
            ir_shift_r <= `IR_IDCODE;
        end else if (tck_rise) begin
            if (state == ST_CAP_IR) begin
                ir_shift_r <= `IR_CAPTURE;
            end else if (state == ST_SHIFT_IR) begin
                ir_shift_r <= {tdi_s, ir_shift_r[`IR_W-1:1]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (tap_rst || state == ST_RESET) begin
            ir_r <= `IR_IDCODE;
        end else if (tck_fall && state == ST_UPD_IR) begin
            ir_r <= ir_shift_r;
        end
    end

    // Reserved codes fall to bypass here; the tester must not load them
    function automatic instr_decode_t decode(input logic [`IR_W-1:0] code);
        instr_decode_t d;
        d = '{test_mode: 1'b0, outputs_hiz: 1'b0, drive_bsr: 1'b0,
              bsr_update_en: 1'b0, invert_capture: 1'b0, sel: DR_BYPASS};
        unique case (code)
            `IR_EXTEST: begin
                d.test_mode     = 1'b1;
                d.drive_bsr     = 1'b1;
                d.bsr_update_en = 1'b1;
                d.sel           = DR_BSR;
            end
            `IR_IDCODE: begin
                d.sel = DR_IDENT;
            end
            `IR_SAMPLE: begin
                d.bsr_update_en = 1'b1;
                d.sel           = DR_BSR;
            end
            `IR_HIGHZ: begin
                d.test_mode   = 1'b1;
                d.outputs_hiz = 1'b1;
            end
            `IR_CLAMP: begin
                d.test_mode = 1'b1;
                d.drive_bsr = 1'b1;
            end
            `IR_CELL_INV: begin
                d.invert_capture = 1'b1;
                d.sel            = DR_BSR;
            end
            default: begin
                d.sel = DR_BYPASS;
            end
        endcase
        return d;
    endfunction

    assign dec = decode(ir_r);

    // ------------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------------
    logic              bypass_r;
    logic [`ID_W-1:0]  id_shift_r;
    logic [`BSR_W-1:0] bsr_shift_r;
    logic [`BSR_W-1:0] bsr_upd_r;
    logic              cap_dr;
    logic              shift_dr;

    // Capture acts on the rise that leaves Capture-DR
    assign cap_dr   = tck_rise && state == ST_CAP_DR;
    assign shift_dr = tck_rise && state == ST_SHIFT_DR;

    always_ff @(posedge clk) begin
        if (tap_rst) begin
            bypass_r <= `BYPASS_CAP;
        end else if (dec.sel == DR_BYPASS) begin
            if (cap_dr) begin
                bypass_r <= `BYPASS_CAP;
            end else if (shift_dr) begin
                bypass_r <= tdi_s;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (tap_rst) begin
            id_shift_r <= `ID_VALUE;
        end else if (dec.sel == DR_IDENT) begin
            if (cap_dr) begin
                id_shift_r <= `ID_VALUE;
            end else if (shift_dr) begin
                id_shift_r <= {tdi_s, id_shift_r[`ID_W-1:1]};
            end
        end
    end

    // Cell test reads back the held cells inverted, so both the shift
    // stage and the held stage are exercised in one pass
    always_ff @(posedge clk) begin
        if (tap_rst || state == ST_RESET) begin
            bsr_shift_r <= `BSR_ONES;
        end else if (dec.sel == DR_BSR) begin
            if (cap_dr) begin
                bsr_shift_r <= dec.invert_capture ? ~bsr_upd_r
                                                  : cell_in;
            end else if (shift_dr) begin
                bsr_shift_r <= {tdi_s, bsr_shift_r[`BSR_W-1:1]};
            end
        end
    end

    // Clamp leaves the update enable off, so held outputs cannot move
    always_ff @(posedge clk) begin
        if (tap_rst || state == ST_RESET) begin
            bsr_upd_r <= `BSR_ONES;
        end else if (tck_fall && state == ST_UPD_DR && dec.bsr_update_en) begin
            bsr_upd_r <= bsr_shift_r;
        end
    end

    // ------------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------------
    logic tdo_r;
    logic tdo_oe_n_r;
    logic dr_lsb;

    always_comb begin
        unique case (dec.sel)
            DR_IDENT: dr_lsb = id_shift_r[0];
            DR_BSR:   dr_lsb = bsr_shift_r[0];
            default:  dr_lsb = bypass_r;
        endcase
    end

    // Driven only during shift states; released on the first fall in Exit1
    always_ff @(posedge clk) begin
        if (tap_rst) begin
            tdo_r      <= 1'b0;
            tdo_oe_n_r <= 1'b1;
        end else if (tck_fall) begin
            if (state == ST_SHIFT_DR) begin
                tdo_r      <= dr_lsb;
                tdo_oe_n_r <= 1'b0;
            end else if (state == ST_SHIFT_IR) begin
                tdo_r      <= ir_shift_r[0];
                tdo_oe_n_r <= 1'b0;
            end else begin
                tdo_oe_n_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------------
    logic test_mode_r;
    logic drive_bsr_r;
    logic outputs_hiz_r;

    always_ff @(posedge clk) begin
        if (tap_rst) begin
            test_mode_r   <= 1'b0;
            drive_bsr_r   <= 1'b0;
            outputs_hiz_r <= 1'b0;
        end else begin
            test_mode_r   <= dec.test_mode;
            drive_bsr_r   <= dec.drive_bsr;
            outputs_hiz_r <= dec.outputs_hiz;
        end
    end

    assign tdo         = tdo_r;
    assign tdo_oe_n    = tdo_oe_n_r;
    assign bsr_out     = bsr_upd_r;
    assign test_mode   = test_mode_r;
    assign drive_bsr   = drive_bsr_r;
    assign outputs_hiz = outputs_hiz_r;
    assign tap_state   = state;

endmodule

`default_nettype wire

//--- tap_params.svh
// Constants for the boundary-scan test port: codes, widths, reset values.
// Assumes inclusion by the package and the top module of the test port.
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

// ----------------------------------------------------------------------
// Register sizes
// ----------------------------------------------------------------------
`define IR_W          8
`define ID_W          32
`define BSR_W         110
`define SYNC_W        4

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define IR_EXTEST     8'h00
`define IR_IDCODE     8'h81
`define IR_SAMPLE     8'h82
`define IR_HIGHZ      8'h06
`define IR_CLAMP      8'h87
`define IR_CELL_INV   8'h0C
`define IR_CAPTURE    8'h81

// ----------------------------------------------------------------------
// Reset and capture values
// ----------------------------------------------------------------------
// Identification value is arbitrary; the low bit stays one by convention
`define ID_VALUE      32'h1234_5001
// Cells left undefined at reset; none are known, so all clear to zero
`define BSR_ONES      110'h0
`define BYPASS_CAP    1'b0

`endif

//--- tap_pkg.sv
// Types shared by the boundary-scan test port modules.
// Assumes tap_params.svh is on the include path.
`include "tap_params.svh"

package tap_pkg;

    // ------------------------------------------------------------------
    // Controller states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_RESET      = 16'h0001,
        ST_IDLE       = 16'h0002,
        ST_SEL_DR     = 16'h0004,
        ST_CAP_DR     = 16'h0008,
        ST_SHIFT_DR   = 16'h0010,
        ST_EXIT1_DR   = 16'h0020,
        ST_PAUSE_DR   = 16'h0040,
        ST_EXIT2_DR   = 16'h0080,
        ST_UPD_DR     = 16'h0100,
        ST_SEL_IR     = 16'h0200,
        ST_CAP_IR     = 16'h0400,
        ST_SHIFT_IR   = 16'h0800,
        ST_EXIT1_IR   = 16'h1000,
        ST_PAUSE_IR   = 16'h2000,
        ST_EXIT2_IR   = 16'h4000,
        ST_UPD_IR     = 16'h8000
    } tap_state_t;

    // ------------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DR_BYPASS = 2'h0,
        DR_IDENT  = 2'h1,
        DR_BSR    = 2'h2
    } dr_sel_t;

    typedef struct packed {
        logic    test_mode;
        logic    outputs_hiz;
        logic    drive_bsr;
        logic    bsr_update_en;
        logic    invert_capture;
        dr_sel_t sel;
    } instr_decode_t;

endpackage

//--- pin_sync.sv
// Two-flop synchroniser for the test port pins.
// Assumes the pins are asynchronous to clk; reset value is all zero.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 4
) (
    // System
    input  wire logic             clk,
    input  wire logic             rst,
    // Pins in, synchronised out
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;

endmodule

`default_nettype wire

//--- tap_fsm.sv
// Sixteen-state test access port controller.
// Assumes step is a one-cycle pulse on each rising test-clock edge.
`timescale 1ns/1ps
`default_nettype none

module tap_fsm
    import tap_pkg::*;
(
    // System
    input  wire logic       clk,
    input  wire logic       rst,
    // Sampled test port
    input  wire logic       step,
    input  wire logic       tms,
    // State
    output tap_state_t      state_r
);

    tap_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RESET:    state_nxt = tms ? ST_RESET    : ST_IDLE;
            ST_IDLE:     state_nxt = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   state_nxt = tms ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   state_nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_nxt = tms ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: state_nxt = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_nxt = tms ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   state_nxt = tms ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   state_nxt = tms ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   state_nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_nxt = tms ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: state_nxt = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_nxt = tms ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   state_nxt = tms ? ST_SEL_DR   : ST_IDLE;
            default:     state_nxt = ST_RESET;
        endcase
    end

    // Transitions follow the standard graph; TMS high reaches reset in 5
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_RESET;
        end else if (step) begin
            state_r <= state_nxt;
        end
    end

endmodule

`default_nettype wire

//--- boundary_scan_tap_controller_assertions.sv
// Port checker for the boundary-scan test port, bound to its top module.
// Assumes tap_params.svh on the include path and tap_pkg compiled first.
`include "tap_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tap_port_checker
    import tap_pkg::*;
(
    // System
    input  wire logic              clk,
    input  wire logic              rst,
    // Test port pins
    input  wire logic              tck,
    input  wire logic              tms,
    input  wire logic              tdi,
    input  wire logic              trst_n,
    input  wire logic              tdo,
    input  wire logic              tdo_oe_n,
    // Boundary cells and modes
    input  wire logic [`BSR_W-1:0] cell_in,
    input  wire logic [`BSR_W-1:0] bsr_out,
    input  wire logic              test_mode,
    input  wire logic              drive_bsr,
    input  wire logic              outputs_hiz,
    input  wire tap_state_t        tap_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_trst_forces_reset: assert property (
        $fell(trst_n) |-> ##[1:4] tap_state == ST_RESET)
        else $error("test reset did not reach reset state");
    a_state_onehot: assert property (
        $onehot(tap_state)) else $error("controller state not one-hot");
    a_capdr_next: assert property (
        $changed(tap_state) && $past(tap_state) == ST_CAP_DR
        |-> tap_state inside {ST_SHIFT_DR, ST_EXIT1_DR, ST_RESET})
        else $error("bad successor of data capture");
    a_selir_leaves: assert property (
        $rose(tap_state == ST_SEL_IR)
        |-> ##[1:20] tap_state inside {ST_CAP_IR, ST_RESET})
        else $error("select state held too long");
    a_tdo_on_fall: assert property (
        $changed(tdo) |-> !tck && !$past(tck, 2))
        else $error("serial out moved off a falling test clock");
    a_oe_released: assert property (
        tap_state inside {ST_IDLE, ST_PAUSE_DR, ST_PAUSE_IR, ST_UPD_DR,
                          ST_UPD_IR} |-> tdo_oe_n)
        else $error("serial out still driven outside shifting");
    a_bsr_on_update: assert property (
        $changed(bsr_out) |-> tap_state inside {ST_UPD_DR, ST_RESET})
        else $error("boundary outputs changed outside data update");
    a_mode_on_update: assert property (
        $changed(test_mode) || $changed(drive_bsr)
        |-> tap_state inside {ST_UPD_IR, ST_RESET})
        else $error("mode changed outside instruction update");
    a_reset_defaults: assert property (
        (tap_state == ST_RESET) [*3] |-> !test_mode && !drive_bsr
        && !outputs_hiz && bsr_out == `BSR_ONES)
        else $error("reset state left test logic active");
    a_hiz_mode: assert property (
        outputs_hiz |-> test_mode && !drive_bsr)
        else $error("high impedance mode decode wrong");
    a_clamp_mode: assert property (
        drive_bsr |-> test_mode && !outputs_hiz)
        else $error("boundary drive without test mode");

    cover property (tap_state == ST_PAUSE_DR);
    cover property ($changed(bsr_out) && tap_state == ST_UPD_DR);
    cover property (outputs_hiz);
endmodule

bind boundary_scan_tap_controller tap_port_checker u_chk (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .cell_in(cell_in),
    .bsr_out(bsr_out), .test_mode(test_mode), .drive_bsr(drive_bsr),
    .outputs_hiz(outputs_hiz), .tap_state(tap_state)
);

`default_nettype wire

//--- scan_master.sv
// Model of the external test controller driving the four-wire link.
// Assumes clk at 100 MHz; one test clock is 16 cycles, idle low.
`timescale 1ns/1ps
`default_nettype none

module scan_master (
    // System
    input  wire logic clk,
    // Link
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One test clock; tdi goes stale once the synchroniser has it
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge clk);
        q = tdo;
        tck <= 1'b1;
        repeat (4) @(posedge clk);
        tdi <= ~d;
        repeat (4) @(posedge clk);
        tck <= 1'b0;
    endtask

    // Scan from idle back to idle, optionally pausing halfway
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        input logic pz, output logic [127:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) begin
            step(1'b1, 1'b0, q);
        end
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1 || (pz && i == n / 2), din[i], q);
            dout[i] = q;
            if (pz && i == n / 2) begin
                step(1'b0, 1'b0, q);
                step(1'b1, 1'b0, q);
                step(1'b0, 1'b0, q);
            end
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
endmodule

`default_nettype wire

//--- boundary_scan_tap_controller_tb_top.sv
// Self-checking bench for the boundary-scan test port.
// Assumes the design files, checker and scan_master are compiled first.
`include "tap_params.svh"
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_tap_controller_tb_top;
    import tap_pkg::*;

    logic              clk, rst, trst_n, tck, tms, tdi, tdo, tdo_oe_n;
    logic              test_mode, drive_bsr, outputs_hiz, q;
    logic [`BSR_W-1:0] cell_in, bsr_out, p, inv;
    tap_state_t        tap_state;
    logic [127:0]      got, exp_q[$];
    logic [7:0]        codes[14];
    event              got_ev;
    int                mismatches, num_checks;

    boundary_scan_tap_controller dut (
        .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .cell_in(cell_in),
        .bsr_out(bsr_out), .test_mode(test_mode), .drive_bsr(drive_bsr),
        .outputs_hiz(outputs_hiz), .tap_state(tap_state));
    // A released line reads inverted, so a missing drive is caught
    scan_master pm (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
                    .tdo(tdo_oe_n ? ~tdo : tdo));

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Note the expected scan-out, then scan
    task automatic xfer(input logic ir, input int n, input logic [127:0] d,
                        input logic pz, input logic [127:0] exp);
        exp_q.push_back(exp);
        pm.scan(ir, n, d, pz, got);
        ->got_ev;
    endtask

    function automatic logic [127:0] rnd();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction

    // ------------------------------------------------------------------
    // Clock, monitor, watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        forever begin
            @(got_ev);
            chk(got, exp_q.pop_front());
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        // Bypass codes and the two modified modes; reserved ones left out
        codes = '{8'h03, 8'h84, 8'h05, 8'h88, 8'h09, 8'h0A, 8'h8B, 8'h8D,
                  8'h8E, 8'h0F, 8'hFF, 8'h10, 8'h06, 8'h87};
        rst = 1'b1;
        trst_n = 1'b0;
        cell_in = '0;
        void'($urandom(17));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        trst_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk(tap_state, ST_RESET);
        chk(bsr_out, `BSR_ONES);
        chk({test_mode, drive_bsr, outputs_hiz, tdo_oe_n}, 4'h1);
        pm.step(1'b0, 1'b0, q);
        xfer(1'b0, 32, rnd(), 1'b1, `ID_VALUE);
        $display("test identification done");

        cell_in <= `BSR_W'(rnd());
        p = `BSR_W'(rnd());
        xfer(1'b1, 8, `IR_EXTEST, 1'b0, `IR_CAPTURE);
        chk({test_mode, drive_bsr}, 2'h3);
        xfer(1'b0, `BSR_W, p, 1'b0, cell_in);
        chk(bsr_out, p);
        inv = ~p;
        xfer(1'b1, 8, `IR_CELL_INV, 1'b0, `IR_CAPTURE);
        chk(test_mode, 1'b0);
        xfer(1'b0, `BSR_W, rnd(), 1'b0, inv);
        $display("test boundary register done");

        foreach (codes[k]) begin
            xfer(1'b1, 8, codes[k], 1'b0, `IR_CAPTURE);
            chk({test_mode, outputs_hiz, drive_bsr},
                {codes[k] == 8'h06 || codes[k] == 8'h87, codes[k] == 8'h06,
                 codes[k] == 8'h87});
            q = 1'($urandom);
            // Three bits: the captured zero, then both bits fed in
            xfer(1'b0, 3, {q, 1'b1}, 1'b0, {q, 1'b1, 1'b0});
        end
        chk(bsr_out, p);
        $display("test bypass codes done");

        cell_in <= `BSR_W'(rnd());
        p = `BSR_W'(rnd());
        xfer(1'b1, 8, `IR_SAMPLE, 1'b1, `IR_CAPTURE);
        xfer(1'b0, `BSR_W, p, 1'b0, cell_in);
        chk({bsr_out, test_mode}, {p, 1'b0});
        $display("test sample preload done");

        pm.step(1'b1, 1'b0, q);
        pm.step(1'b0, 1'b0, q);
        pm.step(1'b0, 1'b0, q);
        repeat (5) pm.step(1'b1, 1'b0, q);
        chk(tap_state, ST_RESET);
        pm.step(1'b0, 1'b0, q);
        xfer(1'b0, 32, rnd(), 1'b0, `ID_VALUE);
        xfer(1'b1, 8, `IR_EXTEST, 1'b0, `IR_CAPTURE);
        // Load a pattern first so the test reset has something to clear
        xfer(1'b0, `BSR_W, p, 1'b0, cell_in);
        chk(bsr_out, p);
        trst_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk({tap_state, bsr_out, test_mode},
            {ST_RESET, `BSR_ONES, 1'b0});
        trst_n <= 1'b1;
        repeat (6) @(posedge clk);
        $display("test resets done");
        complete_run();
    end
endmodule

`default_nettype wire
